// [src/scs_port.sv]
// module: client select spi port with axi4-lite registers and interrupt
// How it works
// - select idles high and its falling edge starts a new transfer.
// - select returning high drops partly received bits for realignment.
// - select control is active only in client mode with mode field 0100.
// - while select is low the port shifts both ways and drives data out.
// - select going high floats the data output even mid byte.
// - select high in that mode, or enable cleared, zeroes the bit count.
// - host mode sleep freezes shifting, which resumes on wake.
// - client shifting runs on the pin clock, flagging after eight bits.
// - data moves most significant bit first both ways.
// - a full byte goes to the buffer unless buffer full is set without overwrite enable; it always sets buffer full and the flag.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
module scs_port
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_clock_pin,
   input wire logic serial_data_in,
   input wire logic client_select_n,
   output logic serial_clock_out,
   output logic serial_clock_oe,
   output logic serial_data_out,
   output logic serial_data_oe,
   output logic irq
);
   typedef enum logic [1:0] {SCS_IDLE, SCS_RUN, SCS_DONE} scs_state_t;

   scs_link_if link ();
   scs_pin_sync u_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .sck_pin(serial_clock_pin),
      .sdi_pin(serial_data_in),
      .sel_n_pin(client_select_n),
      .link(link)
   );

   // -----------------------------------------
   // registers
   // -----------------------------------------
   logic [7:0] ctrl1_q;
   logic [7:0] ctrl3_q;
   logic [7:0] status_q;
   logic [7:0] buf_q;
   logic [7:0] sr_q;
   logic [3:0] cnt_q;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_mask_q;
   logic sleep_q;
   logic sck_d1_q;
   logic sdo_q;
   logic sdo_oe_q;
   logic sck_out_q;
   logic sck_oe_q;
   logic irq_q;
   logic [7:0] div_q;
   scs_state_t host_q;

   logic [3:0] mode;
   logic en;
   logic clock_idle_polarity;
   logic cke;
   logic is_client;
   logic sel_ctl;
   logic sel_act;
   logic port_rst;
   logic sck_rise;
   logic sck_fall;
   logic smp_edge;
   logic out_edge;
   logic byte_done;
   logic wr_buf;
   logic rd_buf;
   logic write_collision_flag_ev;
   logic ovf_ev;
   logic busy;
   logic host_tick;
   logic rd_stat;
   logic [31:0] wdata_q;

   assign mode = ctrl1_q[scs_pkg::MODE_LSB +: scs_pkg::MODE_W];
   assign en = ctrl1_q[scs_pkg::CTRL1_EN];
   assign clock_idle_polarity = ctrl1_q[scs_pkg::CTRL1_CKP];
   assign cke = status_q[scs_pkg::STAT_CKE];
   assign is_client = (mode == scs_pkg::MODE_CLIENT_SEL) ||
      (mode == scs_pkg::MODE_CLIENT_NOSEL);
   assign sel_ctl = en && (mode == scs_pkg::MODE_CLIENT_SEL);
   // only the synchronised select is used
   assign sel_act = sel_ctl && !link.sel_n;
   // idle high select keeps the count at zero until it falls
   assign port_rst = !en || (sel_ctl && link.sel_n);

   // -----------------------------------------
   // edge finding on the sampled pin clock
   // -----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sck_d1_q <= 1'b0;
      else
         sck_d1_q <= link.sck;
   end

   // host clock from a divider enable; sleep stops it
   always_ff @(posedge aclk)
   begin
      if (!aresetn || host_tick)
         div_q <= scs_pkg::BYTE_ZERO;
      else if (!sleep_q)
         div_q <= div_q + 8'h01;
   end
   // no tick while asleep, so state freezes
   assign host_tick = !sleep_q &&
      (div_q == 8'(scs_pkg::HOST_DIV - 1));

   // host generates sck by toggling, client edges come from the pin
   always_ff @(posedge aclk)
   begin
      if (!aresetn || port_rst || is_client)
      begin
         sck_out_q <= 1'b0;
         host_q <= SCS_IDLE;
      end
      else
      begin
         case (host_q)
            SCS_IDLE:
            begin
               sck_out_q <= clock_idle_polarity;
               if (wr_buf && !busy)
                  host_q <= SCS_RUN;
            end
            SCS_RUN:
            begin
               if (host_tick)
                  sck_out_q <= !sck_out_q;
               if (byte_done)
                  host_q <= SCS_DONE;
            end
            SCS_DONE:
               host_q <= SCS_IDLE;
            default:
               host_q <= SCS_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sck_oe_q <= 1'b0;
      else
         sck_oe_q <= en && !is_client;
   end

   always_comb
   begin
      if (is_client)
      begin
         sck_rise = link.sck && !sck_d1_q;
         sck_fall = !link.sck && sck_d1_q;
      end
      else
      begin
         sck_rise = host_q == SCS_RUN && host_tick && !sck_out_q;
         sck_fall = host_q == SCS_RUN && host_tick && sck_out_q;
      end
      // idle level ckp: leading edge leaves idle
      smp_edge = (clock_idle_polarity ^ cke) ? sck_fall : sck_rise;
      out_edge = (clock_idle_polarity ^ cke) ? sck_rise : sck_fall;
   end

   // -----------------------------------------
   // shift register and bit counter
   // -----------------------------------------
   assign busy = cnt_q != scs_pkg::BIT_ZERO;
   assign byte_done = smp_edge && !port_rst &&
      (mode != scs_pkg::MODE_CLIENT_SEL || sel_act) &&
      cnt_q == 4'(scs_pkg::BYTE_BITS - 1);
   assign write_collision_flag_ev = wr_buf && busy;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || port_rst)
         cnt_q <= scs_pkg::BIT_ZERO;
      // client counts pin clock edges, also in sleep
      else if (smp_edge && (mode != scs_pkg::MODE_CLIENT_SEL || sel_act))
         cnt_q <= byte_done ? scs_pkg::BIT_ZERO : cnt_q + 4'h1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sr_q <= scs_pkg::BYTE_ZERO;
      else if (wr_buf && (!busy || ctrl3_q[scs_pkg::CTRL3_BUFFER_OVERWRITE_ENABLE]))
         sr_q <= wdata_q[7:0];
      else if (smp_edge && !port_rst)
         sr_q <= {sr_q[6:0], link.sdi};
   end

   // float one aclk after the synchronised select rises, even mid byte
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !en)
      begin
         sdo_q <= 1'b0;
         sdo_oe_q <= 1'b0;
      end
      else
      begin
         sdo_oe_q <= (mode == scs_pkg::MODE_CLIENT_SEL) ? sel_act : 1'b1;
         if (wr_buf && !busy)
            sdo_q <= wdata_q[7];
         else if (out_edge && busy)
            sdo_q <= sr_q[7];
         else if (!busy && !wr_buf)
            sdo_q <= sr_q[7];
      end
   end

   // -----------------------------------------
   // status, buffer and flags
   // -----------------------------------------
   // received byte to buffer; set beats read clear
   assign ovf_ev = byte_done && status_q[scs_pkg::STAT_BF];
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         buf_q <= scs_pkg::BYTE_ZERO;
      else if (byte_done &&
         (!status_q[scs_pkg::STAT_BF] || ctrl3_q[scs_pkg::CTRL3_BUFFER_OVERWRITE_ENABLE]))
         buf_q <= {sr_q[6:0], link.sdi};
   end

   // byte flag with mask gives the wake interrupt
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_stat_q <= 3'b000;
      else
         irq_stat_q <= (rd_stat ? 3'b000 : irq_stat_q) |
            {ovf_ev, write_collision_flag_ev, byte_done};
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_q <= 1'b0;
      else
         irq_q <= |(irq_stat_q & irq_mask_q);
   end

   // -----------------------------------------
   // axi4-lite slave
   // -----------------------------------------
   logic aw_q;
   logic w_q;
   logic [7:0] awaddr_q;
   logic do_wr;
   logic do_rd;
   assign do_wr = aw_q && w_q && !s_axi_bvalid;
   assign wr_buf = do_wr && awaddr_q == scs_pkg::ADDR_DATA;
   assign do_rd = s_axi_arvalid && s_axi_arready;
   assign rd_buf = do_rd && s_axi_araddr == scs_pkg::ADDR_DATA;
   assign rd_stat = do_rd && s_axi_araddr == scs_pkg::ADDR_IRQ_STAT;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= scs_pkg::BYTE_ZERO;
         wdata_q <= scs_pkg::WORD_ZERO;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= scs_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
         end
         if (do_wr)
         begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q > scs_pkg::ADDR_POWER ||
               awaddr_q[1:0] != 2'b00) ? scs_pkg::RESP_SLVERR
               : scs_pkg::RESP_OKAY;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready = !w_q && !s_axi_bvalid;

   // software registers; wdata_q holds the write data
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl1_q <= scs_pkg::CTRL1_RST;
         ctrl3_q <= scs_pkg::BYTE_ZERO;
         status_q <= scs_pkg::STATUS_RST;
         irq_mask_q <= 3'b000;
         sleep_q <= 1'b0;
      end
      else
      begin
         if (do_wr && s_axi_wstrb[0])
         begin
            case (awaddr_q)
               scs_pkg::ADDR_CTRL1: ctrl1_q[5:0] <= wdata_q[5:0];
               scs_pkg::ADDR_CTRL3: ctrl3_q <= wdata_q[7:0];
               scs_pkg::ADDR_STATUS: status_q[7:6] <= wdata_q[7:6];
               scs_pkg::ADDR_IRQ_MASK: irq_mask_q <= wdata_q[2:0];
               scs_pkg::ADDR_POWER: sleep_q <= wdata_q[scs_pkg::PWR_SLEEP];
               default: ;
            endcase
         end
         // collision and overflow: set wins over software clear
         if (do_wr && s_axi_wstrb[0] && awaddr_q == scs_pkg::ADDR_CTRL1)
            ctrl1_q[7:6] <= wdata_q[7:6] & ctrl1_q[7:6];
         if (write_collision_flag_ev)
            ctrl1_q[scs_pkg::CTRL1_WRITE_COLLISION_FLAG] <= 1'b1;
         if (ovf_ev)
            ctrl1_q[scs_pkg::CTRL1_OVF] <= 1'b1;
         // buffer full: set beats read clear
         if (byte_done)
            status_q[scs_pkg::STAT_BF] <= 1'b1;
         else if (rd_buf)
            status_q[scs_pkg::STAT_BF] <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= scs_pkg::WORD_ZERO;
         s_axi_rresp <= scs_pkg::RESP_OKAY;
      end
      else if (do_rd)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= scs_pkg::RESP_OKAY;
         case (s_axi_araddr)
            scs_pkg::ADDR_CTRL1: s_axi_rdata <= {24'h00_0000, ctrl1_q};
            scs_pkg::ADDR_CTRL3: s_axi_rdata <= {24'h00_0000, ctrl3_q};
            scs_pkg::ADDR_STATUS: s_axi_rdata <= {24'h00_0000, status_q};
            scs_pkg::ADDR_DATA: s_axi_rdata <= {24'h00_0000, buf_q};
            scs_pkg::ADDR_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_q};
            scs_pkg::ADDR_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_q};
            scs_pkg::ADDR_POWER: s_axi_rdata <= {31'h0, sleep_q};
            default:
            begin
               s_axi_rdata <= scs_pkg::WORD_ZERO;
               s_axi_rresp <= scs_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
   assign s_axi_arready = !s_axi_rvalid;

   assign serial_clock_out = sck_out_q;
   assign serial_clock_oe = sck_oe_q;
   assign serial_data_out = sdo_q;
   assign serial_data_oe = sdo_oe_q;
   assign irq = irq_q;
endmodule

// [src/scs_pkg.sv]
// package: register map, field layout and constants of the client select spi port
package scs_pkg;
   // register byte offsets (aligned words)
   localparam logic [7:0] ADDR_CTRL1 = 8'h00;
   localparam logic [7:0] ADDR_CTRL3 = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_DATA = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
   localparam logic [7:0] ADDR_POWER = 8'h18;
   // port_control_one fields
   localparam int CTRL1_WRITE_COLLISION_FLAG = 7;
   localparam int CTRL1_OVF = 6;
   localparam int CTRL1_EN = 5;
   localparam int CTRL1_CKP = 4;
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 4;
   // port_status fields
   localparam int STAT_SMP = 7;
   localparam int STAT_CKE = 6;
   localparam int STAT_BF = 0;
   // port_control_three field
   localparam int CTRL3_BUFFER_OVERWRITE_ENABLE = 4;
   // irq status/mask bits
   localparam int IRQ_BYTE = 0;
   localparam int IRQ_WRITE_COLLISION_FLAG = 1;
   localparam int IRQ_OVF = 2;
   localparam int IRQ_W = 3;
   // power register bit: host sleep request
   localparam int PWR_SLEEP = 0;
   // mode encodings
   localparam logic [3:0] MODE_CLIENT_SEL = 4'h4;
   localparam logic [3:0] MODE_CLIENT_NOSEL = 4'h5;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   localparam int BYTE_BITS = 8;
   // host mode divider: clock toggle enable every N aclk, two per bit
   localparam int HOST_DIV = 4;
endpackage

// [src/scs_link_if.sv]
// interface: synchronised serial pin levels between the synchroniser and the shifter
interface scs_link_if;
   logic sck;
   logic sdi;
   logic sel_n;
   modport src
   (
      output sck,
      output sdi,
      output sel_n
   );
   modport dst
   (
      input sck,
      input sdi,
      input sel_n
   );
endinterface

// [src/scs_pin_sync.sv]
// module: two flip-flop synchronisers for the serial pins
module scs_pin_sync
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sck_pin,
   input wire logic sdi_pin,
   input wire logic sel_n_pin,
   scs_link_if.src link
);
   logic [2:0] meta_q;
   logic [2:0] sync_q;

   // first stage read only by the second; sel_n idles high
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= 3'b100;
         sync_q <= 3'b100;
      end
      else
      begin
         meta_q <= {sel_n_pin, sdi_pin, sck_pin};
         sync_q <= meta_q;
      end
   end

   assign link.sck = sync_q[0];
   assign link.sdi = sync_q[1];
   assign link.sel_n = sync_q[2];
endmodule

// [dv/scs_port_asserts.sv]
// checker: port level assertions for the client select spi port
module scs_port_asserts
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic client_select_n,
   input wire logic serial_clock_oe,
   input wire logic serial_data_oe,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // shadow of control writes
   // ----------------------------------------
   // mode is internal, so it is rebuilt from the bus traffic
   logic [7:0] aw_q;
   logic [31:0] w_q;
   logic [7:0] ctrl_q;
   logic bv_q;
   logic wr_done;
   logic sel_mode;
   logic client;
   assign wr_done = s_axi_bvalid && !bv_q;
   assign sel_mode = ctrl_q[scs_pkg::CTRL1_EN]
      && ctrl_q[3:0] == scs_pkg::MODE_CLIENT_SEL;
   assign client = ctrl_q[scs_pkg::CTRL1_EN]
      && (ctrl_q[3:0] == scs_pkg::MODE_CLIENT_SEL
      || ctrl_q[3:0] == scs_pkg::MODE_CLIENT_NOSEL);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_q <= 8'h00;
         w_q <= 32'h0000_0000;
         ctrl_q <= 8'h00;
         bv_q <= 1'b0;
      end
      else
      begin
         bv_q <= s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
            aw_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
            w_q <= s_axi_wdata;
         if (wr_done && aw_q == scs_pkg::ADDR_CTRL1)
            ctrl_q <= w_q[7:0];
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped early");
   property p_ar_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_ar_lat: assert property (p_ar_lat)
      else $error("read answer late");
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > scs_pkg::ADDR_POWER
      |=> s_axi_rresp == scs_pkg::RESP_SLVERR
      && s_axi_rdata == scs_pkg::WORD_ZERO;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");
   property p_aw_refuse;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_refuse: assert property (p_aw_refuse)
      else $error("write taken while response pending");
   property p_sel_drive;
      sel_mode && $fell(client_select_n) |-> ##[1:6] serial_data_oe;
   endproperty
   a_sel_drive: assert property (p_sel_drive)
      else $error("data output not driven after select low");
   property p_sel_float;
      sel_mode && $rose(client_select_n) |-> ##[1:6] !serial_data_oe;
   endproperty
   a_sel_float: assert property (p_sel_float)
      else $error("data output still driven after select high");
   property p_sel_sync;
      sel_mode && $fell(client_select_n) |=> !serial_data_oe;
   endproperty
   a_sel_sync: assert property (p_sel_sync)
      else $error("select used before synchronising");
   property p_sel_idle;
      sel_mode && client_select_n [*6] |-> !serial_data_oe;
   endproperty
   a_sel_idle: assert property (p_sel_idle)
      else $error("data output driven while deselected");
   property p_client_clk;
      client [*3] |-> !serial_clock_oe;
   endproperty
   a_client_clk: assert property (p_client_clk)
      else $error("clock driven in client mode");
   property p_mask_off;
      wr_done && aw_q == scs_pkg::ADDR_IRQ_MASK && w_q[2:0] == 3'b000
      |-> ##[1:3] !irq;
   endproperty
   a_mask_off: assert property (p_mask_off)
      else $error("interrupt high while masked");
endmodule

bind scs_port scs_port_asserts i_chk
(
   .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .client_select_n, .serial_clock_oe, .serial_data_oe,
   .irq
);

// [dv/scs_host_model.sv]
// partner: spi host that frames transfers with select
module scs_host_model
(
   output logic sck,
   output logic sdi,
   output logic sel_n,
   input wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // host side of the link
   // ----------------------------------------
   // select idles high
   initial
   begin
      sck = 1'b0;
      sdi = 1'b1;
      sel_n = 1'b1;
   end
   task automatic xfer(input int n, input logic [7:0] tx,
      output logic [7:0] rx);
      int i;
      rx = 8'h00;
      #3;
      sel_n = 1'b0;
      #80;
      for (i = 0; i < n; i++)
      begin
         sdi = tx[7 - i];
         #40;
         sck = 1'b1;
         rx = {rx[6:0], sdo};
         #40;
         sck = 1'b0;
      end
      #40;
      sel_n = 1'b1;
      // released line must not keep a stale level
      sdi = ~sdi;
   endtask
endmodule

// [dv/spi_client_select_sync_tb.sv]
// testbench: client select spi port over axi4-lite
module spi_client_select_sync_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic sck, sdi, sel_n, sdo, sdoe, irq, sck_out, sck_oe;
   logic [7:0] awaddr, araddr, rx;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r;
   int error_cnt = 0;
   int num_checks = 0;
   scs_port i_dut
   (
      .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .serial_clock_pin(sck),
      .serial_data_in(sdi), .client_select_n(sel_n),
      .serial_clock_out(sck_out), .serial_clock_oe(sck_oe),
      .serial_data_out(sdo),
      .serial_data_oe(sdoe), .irq
   );
   scs_host_model i_host
   (
      .sck, .sdi, .sel_n, .sdo(sdoe ? sdo : 1'bz)
   );
   // host mode monitor: data out taken at each rise of the driven clock
   logic h_sck_q = 1'b0;
   logic [7:0] h_rx = 8'h00;
   int h_n = 0;
   always @(negedge aclk)
   begin
      h_sck_q <= sck_out;
      if (sck_out && !h_sck_q)
      begin
         h_rx <= {h_rx[6:0], sdo};
         h_n <= h_n + 1;
      end
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic wrap_up();
      if (error_cnt == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // ready is looked at mid cycle, so it never races the edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      logic ta, tw, tb;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      for (n = 0; n < 100 && !tb; n++)
      begin
         @(negedge aclk);
         ta = awready;
         tw = wready;
         tb = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
         if (tb)
            bready <= 1'b0;
      end
      if (!tb)
      begin
         error_cnt++;
         wrap_up();
      end
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      logic ta, tr;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tr = 1'b0;
      for (n = 0; n < 100 && !tr; n++)
      begin
         @(negedge aclk);
         ta = arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta)
            arvalid <= 1'b0;
         if (tr)
            rready <= 1'b0;
      end
      if (!tr)
      begin
         error_cnt++;
         wrap_up();
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk($sformatf("reg_%h", a), e, d);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      rdc(scs_pkg::ADDR_CTRL1, {24'h00_0000, scs_pkg::CTRL1_RST});
      rdc(scs_pkg::ADDR_STATUS, {24'h00_0000, scs_pkg::STATUS_RST});
      rd(8'h40);
      chk("resp", {30'h0, scs_pkg::RESP_SLVERR}, {30'h0, r});
      chk("err_data", 32'h0000_0000, d);
      wr(scs_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
      chk("wresp", {30'h0, scs_pkg::RESP_OKAY}, {30'h0, r});
      wr(8'h40, 32'h0000_0000);
      chk("wresp_err", {30'h0, scs_pkg::RESP_SLVERR}, {30'h0, r});
      rdc(scs_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
   endtask
   task automatic t_byte();
      wr(scs_pkg::ADDR_CTRL1, 32'h0000_0024);
      wr(scs_pkg::ADDR_DATA, 32'h0000_00A5);
      i_host.xfer(8, 8'h3C, rx);
      chk("tx_byte", 32'h0000_00A5, {24'h0, rx});
      chk("irq", 32'h1, {31'h0, irq});
      rdc(scs_pkg::ADDR_STATUS, 32'h0000_0001);
      rdc(scs_pkg::ADDR_DATA, 32'h0000_003C);
      rdc(scs_pkg::ADDR_STATUS, 32'h0000_0000);
      rdc(scs_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
      @(negedge aclk);
      @(negedge aclk);
      chk("irq_clr", 32'h0, {31'h0, irq});
   endtask
   task automatic t_abort();
      i_host.xfer(3, 8'hFF, rx);
      repeat (6) @(negedge aclk);
      chk("oe_float", 32'h0, {31'h0, sdoe});
      rdc(scs_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
      i_host.xfer(8, 8'h96, rx);
      rdc(scs_pkg::ADDR_DATA, 32'h0000_0096);
   endtask
   task automatic t_sleep();
      wr(scs_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
      wr(scs_pkg::ADDR_POWER, 32'h0000_0001);
      // clear the byte bit left by the previous scenario
      rdc(scs_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
      i_host.xfer(8, 8'hE1, rx);
      chk("irq_masked", 32'h0, {31'h0, irq});
      wr(scs_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
      @(negedge aclk);
      chk("irq_wake", 32'h1, {31'h0, irq});
      rdc(scs_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
      rdc(scs_pkg::ADDR_DATA, 32'h0000_00E1);
      wr(scs_pkg::ADDR_POWER, 32'h0000_0000);
   endtask
   task automatic t_nosel();
      wr(scs_pkg::ADDR_CTRL1, 32'h0000_0025);
      // select is ignored here, so the byte spans two frames
      i_host.xfer(3, 8'hC3, rx);
      i_host.xfer(5, 8'h18, rx);
      rdc(scs_pkg::ADDR_DATA, 32'h0000_00C3);
   endtask
   task automatic t_host();
      int n0;
      int n1;
      n0 = h_n;
      wr(scs_pkg::ADDR_CTRL1, 32'h0000_0020);
      wr(scs_pkg::ADDR_DATA, 32'h0000_005A);
      wr(scs_pkg::ADDR_POWER, 32'h0000_0001);
      n1 = h_n;
      repeat (40) @(negedge aclk);
      chk("sleep_hold", n1, h_n);
      wr(scs_pkg::ADDR_POWER, 32'h0000_0000);
      repeat (80) @(negedge aclk);
      chk("host_bits", 32'h0000_0008, h_n - n0);
      chk("host_tx", 32'h0000_005A, {24'h0, h_rx});
      chk("sck_oe", 32'h1, {31'h0, sck_oe});
   endtask
   // ----------------------------------------
   // clock, reset and sequence
   // ----------------------------------------
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial
   begin
      aresetn = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_byte();
      t_abort();
      t_sleep();
      t_nosel();
      t_host();
      wrap_up();
   end
endmodule
